// *** design/bit_decode_pkg.sv ***
// Constants, codes and timing for the bit instruction decoder
// Assumes a single core clock; no software-visible registers
package bit_decode_pkg;

  // Instruction forms
  typedef enum logic [3:0] {
    OP_CARRY_COMBINE = 4'h0,
    OP_CLEAR_INVERT = 4'h1,
    OP_SHORT_CLR_INV = 4'h2,
    OP_MOVE_TO_OPND = 4'h3,
    OP_MOVE_TO_CARRY = 4'h4
  } op_form_type;

  // Operand address classes, one-hot
  typedef enum logic [7:0] {
    AM_DATA_REG = 8'h01,
    AM_ADDR_REG = 8'h02,
    AM_INDIRECT = 8'h04,
    AM_DSP8_AREG = 8'h08,
    AM_DSP8_BASE = 8'h10,
    AM_DSP16_AREG = 8'h20,
    AM_DSP16_SB = 8'h40,
    AM_ABS16 = 8'h80
  } addr_mode_type;

  // Operand field codes
  localparam logic [3:0] FLD_DATA_REG_ZERO = 4'h0;
  localparam logic [3:0] FLD_DATA_REG_THREE = 4'h3;
  localparam logic [3:0] FLD_ADDR_REG_ZERO = 4'h4;
  localparam logic [3:0] FLD_ADDR_REG_ONE = 4'h5;
  localparam logic [3:0] FLD_IND_ZERO = 4'h6;
  localparam logic [3:0] FLD_IND_ONE = 4'h7;
  localparam logic [3:0] FLD_DSP8_ZERO = 4'h8;
  localparam logic [3:0] FLD_DSP8_ONE = 4'h9;
  localparam logic [3:0] FLD_DSP8_SB = 4'ha;
  localparam logic [3:0] FLD_DSP8_FB = 4'hb;
  localparam logic [3:0] FLD_DSP16_ZERO = 4'hc;
  localparam logic [3:0] FLD_DSP16_ONE = 4'hd;
  localparam logic [3:0] FLD_DSP16_SB = 4'he;
  localparam logic [3:0] FLD_ABS16 = 4'hf;

  // Condition index 0..13 shared by both condition encodings
  localparam int COND_COUNT = 14;
  localparam logic [3:0] CI_GEU = 4'h0;
  localparam logic [3:0] CI_GTU = 4'h1;
  localparam logic [3:0] CI_EQ = 4'h2;
  localparam logic [3:0] CI_N = 4'h3;
  localparam logic [3:0] CI_LE = 4'h4;
  localparam logic [3:0] CI_O = 4'h5;
  localparam logic [3:0] CI_GE = 4'h6;
  localparam logic [3:0] CI_LTU = 4'h7;
  localparam logic [3:0] CI_LEU = 4'h8;
  localparam logic [3:0] CI_NE = 4'h9;
  localparam logic [3:0] CI_PZ = 4'ha;
  localparam logic [3:0] CI_GT = 4'hb;
  localparam logic [3:0] CI_NO = 4'hc;
  localparam logic [3:0] CI_LT = 4'hd;

  // 8-bit condition byte ranges
  localparam logic [7:0] CB_LOW_FIRST = 8'h00;
  localparam logic [7:0] CB_LOW_LAST = 8'h06;
  localparam logic [7:0] CB_HIGH_FIRST = 8'hf8;
  localparam logic [7:0] CB_HIGH_LAST = 8'hfe;

  // Byte and cycle figures
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [3:0] CYC_SHORT = 4'h3;
  localparam logic [2:0] LEN_TO_CARRY = 3'h2;
  localparam logic [3:0] CYC_TO_CARRY = 4'h1;
  localparam logic [3:0] CYC_TRUE_EXTRA = 4'h1;
  localparam logic [2:0] LEN_MOVE_EXTRA = 3'h1;
  localparam logic [3:0] CYC_COMB_REG = 4'h3;
  localparam logic [3:0] CYC_COMB_MEM = 4'h7;
  localparam logic [3:0] CYC_COMB_BASE = 4'h4;
  localparam logic [3:0] CYC_CLR_REG = 4'h2;
  localparam logic [3:0] CYC_CLR_MEM = 4'h6;
  localparam logic [3:0] CYC_CLR_BASE = 4'h3;
  localparam logic [3:0] CYC_MOV_REG = 4'h6;
  localparam logic [3:0] CYC_MOV_MEM = 4'ha;
  localparam logic [3:0] CYC_MOV_BASE = 4'h7;
  localparam logic [2:0] LEN_REG = 3'h3;
  localparam logic [2:0] LEN_IND = 3'h2;
  localparam logic [2:0] LEN_DSP8 = 3'h3;
  localparam logic [2:0] LEN_DSP16 = 3'h4;

endpackage

// *** design/bit_instruction_decode.sv ***
// Bit instruction decoder: operand class, condition and length/cycle report
// Assumes inputs synchronous to clk_sys; flags come from the core
// Function
// - Operand codes 0-3 data regs, 4-5 address regs, 6-7 indirect
// - Codes 8-9 dsp8 areg, a-b dsp8 base, c-d dsp16 areg, e sb, f abs
// - Carry-combining ops: 3/3, 2/7, 3/7, 3/4, 4/7, else 4/4
// - Clear and invert general forms: 3/2, 2/6, 3/6, 3/3, 4/6, else 4/3
// - Short clear and invert forms use 11-bit base field, 2 bytes 3 cycles
// - Memory move condition byte: 00-06 and f8-fe
// - Move to operand: 4/6, 3/10, 4/10, 4/7, 5/10, else 5/7
// - Carry move 4-bit condition field, with codes 1011 and 1111 unused
// - Carry move is 2 bytes, 1 cycle, plus 1 if condition true
`timescale 1ns/1ps
module bit_instruction_decode
  import bit_decode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Decode request
  input wire logic dec_valid,
  input wire bit_decode_pkg::op_form_type op_form,
  input wire logic [3:0] operand_field,
  input wire logic [7:0] cond_code,
  input wire logic [10:0] short_bit_addr,
  // Core flags: carry, zero, sign, overflow
  input wire logic [3:0] flags,
  // Decode result
  output logic res_valid,
  output bit_decode_pkg::addr_mode_type addr_mode,
  output logic [1:0] reg_select,
  output logic [10:0] short_addr,
  output logic cond_true,
  output logic illegal,
  output logic [2:0] byte_count,
  output logic [3:0] cycle_count
);

  import bit_decode_pkg::*;

  typedef struct packed {
    logic valid;
    addr_mode_type mode;
    logic [1:0] sel;
    logic [10:0] saddr;
    logic ctrue;
    logic ill;
    logic [2:0] len;
    logic [3:0] cyc;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  addr_mode_type mode_d;
  logic [3:0] cond_idx;
  logic cond_ok;
  logic cond_hold;

  cond_decode_if cdi ();
  assign cdi.wide_sel = (op_form == OP_MOVE_TO_OPND);
  assign cdi.code = cond_code;
  assign cond_idx = cdi.index;
  assign cond_ok = cdi.legal;

  cond_decoder u_cond (
    .cd(cdi)
  );

  function automatic addr_mode_type mode_of(input logic [3:0] f);
    if (f <= FLD_DATA_REG_THREE) mode_of = AM_DATA_REG;
    else if (f <= FLD_ADDR_REG_ONE) mode_of = AM_ADDR_REG;
    else if (f <= FLD_IND_ONE) mode_of = AM_INDIRECT;
    else if (f <= FLD_DSP8_ONE) mode_of = AM_DSP8_AREG;
    else if (f <= FLD_DSP8_FB) mode_of = AM_DSP8_BASE;
    else if (f <= FLD_DSP16_ONE) mode_of = AM_DSP16_AREG;
    else if (f == FLD_DSP16_SB) mode_of = AM_DSP16_SB;
    else mode_of = AM_ABS16;
  endfunction

  // Flags: [0] carry, [1] zero, [2] sign, [3] overflow
  function automatic logic eval_cond(input logic [3:0] idx, input logic [3:0] fl);
    logic c, z, s, o;
    c = fl[0];
    z = fl[1];
    s = fl[2];
    o = fl[3];
    case (idx)
      CI_GEU: eval_cond = c;
      CI_GTU: eval_cond = c & ~z;
      CI_EQ: eval_cond = z;
      CI_N: eval_cond = s;
      CI_LE: eval_cond = (s ^ o) | z;
      CI_O: eval_cond = o;
      CI_GE: eval_cond = ~(s ^ o);
      CI_LTU: eval_cond = ~c;
      CI_LEU: eval_cond = ~(c & ~z);
      CI_NE: eval_cond = ~z;
      CI_PZ: eval_cond = ~s;
      CI_GT: eval_cond = ~((s ^ o) | z);
      CI_NO: eval_cond = ~o;
      CI_LT: eval_cond = s ^ o;
      default: eval_cond = 1'b0;
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    mode_d = mode_of(operand_field);
    cond_hold = eval_cond(cond_idx, flags);
    st_nxt.valid = dec_valid;
    if (dec_valid) begin
      st_nxt.mode = mode_d;
      st_nxt.sel = operand_field[1:0];
      st_nxt.saddr = short_bit_addr;
      st_nxt.ctrue = 1'b0;
      st_nxt.ill = 1'b0;
      unique case (mode_d)
        AM_DATA_REG, AM_ADDR_REG: st_nxt.len = LEN_REG;
        AM_INDIRECT: st_nxt.len = LEN_IND;
        AM_DSP8_AREG, AM_DSP8_BASE: st_nxt.len = LEN_DSP8;
        AM_DSP16_AREG, AM_DSP16_SB, AM_ABS16: st_nxt.len = LEN_DSP16;
      endcase
      unique case (mode_d)
        AM_DATA_REG, AM_ADDR_REG: st_nxt.cyc = CYC_COMB_REG;
        AM_INDIRECT, AM_DSP8_AREG, AM_DSP16_AREG: st_nxt.cyc = CYC_COMB_MEM;
        AM_DSP8_BASE, AM_DSP16_SB, AM_ABS16: st_nxt.cyc = CYC_COMB_BASE;
      endcase
      case (op_form)
        OP_CLEAR_INVERT: begin
          unique case (mode_d)
            AM_DATA_REG, AM_ADDR_REG: st_nxt.cyc = CYC_CLR_REG;
            AM_INDIRECT, AM_DSP8_AREG, AM_DSP16_AREG: st_nxt.cyc = CYC_CLR_MEM;
            AM_DSP8_BASE, AM_DSP16_SB, AM_ABS16: st_nxt.cyc = CYC_CLR_BASE;
          endcase
        end
        OP_SHORT_CLR_INV: begin
          st_nxt.mode = AM_DSP16_SB;
          st_nxt.len = LEN_SHORT;
          st_nxt.cyc = CYC_SHORT;
        end
        OP_MOVE_TO_OPND: begin
          st_nxt.len = 3'(st_nxt.len + LEN_MOVE_EXTRA);
          st_nxt.ill = ~cond_ok;
          st_nxt.ctrue = cond_ok & cond_hold;
          unique case (mode_d)
            AM_DATA_REG, AM_ADDR_REG: st_nxt.cyc = CYC_MOV_REG;
            AM_INDIRECT, AM_DSP8_AREG, AM_DSP16_AREG: st_nxt.cyc = CYC_MOV_MEM;
            AM_DSP8_BASE, AM_DSP16_SB, AM_ABS16: st_nxt.cyc = CYC_MOV_BASE;
          endcase
        end
        OP_MOVE_TO_CARRY: begin
          st_nxt.len = LEN_TO_CARRY;
          st_nxt.ill = ~cond_ok;
          st_nxt.ctrue = cond_ok & cond_hold;
          st_nxt.cyc = (cond_ok & cond_hold) ? 4'(CYC_TO_CARRY + CYC_TRUE_EXTRA)
                                             : CYC_TO_CARRY;
        end
        OP_CARRY_COMBINE: st_nxt.ill = 1'b0;
        default: st_nxt.ill = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '{valid: 1'b0, mode: AM_DATA_REG, sel: 2'h0, saddr: 11'h000, ctrue: 1'b0,
                ill: 1'b0, len: 3'h0, cyc: 4'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_valid = st_r.valid;
  assign addr_mode = st_r.mode;
  assign reg_select = st_r.sel;
  assign short_addr = st_r.saddr;
  assign cond_true = st_r.ctrue;
  assign illegal = st_r.ill;
  assign byte_count = st_r.len;
  assign cycle_count = st_r.cyc;

  carry_time_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_CARRY && cond_ok |=>
      byte_count == 3'h2 && cycle_count == (cond_true ? 4'h2 : 4'h1))
    else $error("carry move timing wrong");
  narrow_ltu_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_CARRY && cond_code[3:0] == 4'h4 && !flags[0] |=>
      cond_true && !illegal && cycle_count == 4'h2)
    else $error("carry move unsigned less wrong");
  comb_reg_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_CARRY_COMBINE && operand_field < 4'h6 |=>
      byte_count == 3'h3 && cycle_count == 4'h3)
    else $error("combine register timing wrong");
  clr_ind_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_CLEAR_INVERT && operand_field[3:1] == 3'h3 |=>
      byte_count == 3'h2 && cycle_count == 4'h6)
    else $error("clear indirect timing wrong");
  clr_base_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_CLEAR_INVERT && operand_field[3:1] == 3'h5 |=>
      byte_count == 3'h3 && cycle_count == 4'h3)
    else $error("clear base timing wrong");
  short_form_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_SHORT_CLR_INV |=>
      byte_count == 3'h2 && cycle_count == 4'h3 && short_addr == $past(short_bit_addr))
    else $error("short form wrong");
  short_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_SHORT_CLR_INV |=>
      addr_mode == AM_DSP16_SB && !cond_true && !illegal)
    else $error("short form class wrong");
  mov_abs_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_OPND && operand_field == 4'hf |=>
      byte_count == 3'h5 && cycle_count == 4'h7)
    else $error("move absolute timing wrong");
  wide_cond_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_OPND && cond_code == 8'hf8 && flags[0] |=>
      !illegal && !cond_true)
    else $error("unsigned less code wrong");
  wide_gap_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_OPND && cond_code == 8'h07 |=> illegal)
    else $error("condition byte gap accepted");
  narrow_gap_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_MOVE_TO_CARRY && cond_code[3:0] == 4'hb |=> illegal)
    else $error("condition field gap accepted");
  mode_map_a: assert property (@(posedge clk_sys) disable iff (reset)
    dec_valid && op_form == OP_CARRY_COMBINE && operand_field == 4'ha |=>
      addr_mode == AM_DSP8_BASE ##1 res_valid == $past(dec_valid))
    else $error("operand class wrong");

endmodule // bit_instruction_decode

// *** design/cond_decode_if.sv ***
// Condition decode carrier between the top and the condition decoder
// Assumes both ends run on the core clock
`timescale 1ns/1ps
interface cond_decode_if;
  logic wide_sel;
  logic [7:0] code;
  logic [3:0] index;
  logic legal;
  modport requester (output wide_sel, output code, input index, input legal);
  modport decoder (input wide_sel, input code, output index, output legal);
endinterface : cond_decode_if

// *** design/cond_decoder.sv ***
// Combinational decoder for the 4-bit and 8-bit condition codes
// Assumes the requester holds code stable while reading index
`timescale 1ns/1ps
module cond_decoder
  import bit_decode_pkg::*;
(
  // Condition request
  cond_decode_if.decoder cd
);

  always_comb begin
    cd.index = CI_GEU;
    cd.legal = 1'b0;
    if (cd.wide_sel) begin
      if (cd.code <= CB_LOW_LAST) begin
        cd.index = cd.code[3:0];
        cd.legal = 1'b1;
      end else if (cd.code >= CB_HIGH_FIRST && cd.code <= CB_HIGH_LAST) begin
        cd.index = 4'(cd.code[2:0]) + CI_LTU;
        cd.legal = 1'b1;
      end
    end else begin
      unique case (cd.code[3:0])
        4'h0: cd.index = CI_GEU;
        4'h1: cd.index = CI_GTU;
        4'h2: cd.index = CI_EQ;
        4'h3: cd.index = CI_N;
        4'h4: cd.index = CI_LTU;
        4'h5: cd.index = CI_LEU;
        4'h6: cd.index = CI_NE;
        4'h7: cd.index = CI_PZ;
        4'h8: cd.index = CI_LE;
        4'h9: cd.index = CI_O;
        4'ha: cd.index = CI_GE;
        4'hc: cd.index = CI_GT;
        4'hd: cd.index = CI_NO;
        4'he: cd.index = CI_LT;
        default: cd.index = CI_GEU;
      endcase
      cd.legal = (cd.code[3:0] != 4'hb) && (cd.code[3:0] != 4'hf);
    end
  end

endmodule // cond_decoder

// *** testbench/bit_instruction_decode_bench.sv ***
// Self-checking bench for the bit instruction decoder
// Assumes bit_decode_pkg and the design files are compiled first
`timescale 1ns/1ps
module bit_instruction_decode_bench;
  import bit_decode_pkg::*;
  localparam int LN [6] = '{3, 2, 3, 3, 4, 4};
  localparam int CY0 [6] = '{3, 7, 7, 4, 7, 4};
  localparam int CY1 [6] = '{2, 6, 6, 3, 6, 3};
  localparam int CY3 [6] = '{6, 10, 10, 7, 10, 7};
  localparam logic [7:0] CB [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hf8,
    8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'h07, 8'hf7, 8'hff};
  localparam logic [3:0] CK [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'h4, 4'h5,
    4'h6, 4'h7, 4'hc, 4'hd, 4'he};
  typedef struct {
    op_form_type f;
    logic [3:0] fld;
    logic [2:0] b;
    logic [3:0] c;
  } row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic dec_valid = 1'b0;
  op_form_type op_form = OP_CARRY_COMBINE;
  logic [3:0] operand_field = 4'h0;
  logic [7:0] cond_code = 8'h00;
  logic [10:0] short_bit_addr = 11'h000;
  logic [3:0] flags = 4'h0;
  logic res_valid;
  addr_mode_type addr_mode;
  logic [1:0] reg_select;
  logic [10:0] short_addr;
  logic cond_true;
  logic illegal;
  logic [2:0] byte_count;
  logic [3:0] cycle_count;
  int errors = 0;
  int n_tests = 0;
  row_type rows[$];
  logic t;

  always #5 clk_sys = ~clk_sys;

  bit_instruction_decode u_bit_instruction_decode (.clk_sys(clk_sys), .reset(reset),
    .dec_valid(dec_valid), .op_form(op_form), .operand_field(operand_field),
    .cond_code(cond_code), .short_bit_addr(short_bit_addr), .flags(flags),
    .res_valid(res_valid), .addr_mode(addr_mode), .reg_select(reg_select),
    .short_addr(short_addr), .cond_true(cond_true), .illegal(illegal),
    .byte_count(byte_count), .cycle_count(cycle_count));

  function automatic int cls(input logic [3:0] f);
    cls = (f < 6) ? 0 : (f < 8) ? 1 : int'(f >> 1) - 2;
  endfunction

  function automatic logic [7:0] mode_of(input logic [3:0] f);
    mode_of = (f == 4'hf) ? 8'h80 : (f < 4) ? 8'h01 : 8'h01 << ((f >> 1) - 1);
  endfunction

  // Condition truth from carry, zero, sign, overflow
  function automatic logic ev(input logic [3:0] k, input logic [3:0] fl);
    logic le;
    le = (fl[2] ^ fl[3]) | fl[1];
    case (k)
      0: ev = fl[0];
      1: ev = fl[0] & ~fl[1];
      2: ev = fl[1];
      3: ev = fl[2];
      4: ev = ~fl[0];
      5: ev = ~(fl[0] & ~fl[1]);
      6: ev = ~fl[1];
      7: ev = ~fl[2];
      8: ev = le;
      9: ev = fl[3];
      10: ev = ~(fl[2] ^ fl[3]);
      12: ev = ~le;
      13: ev = ~fl[3];
      14: ev = fl[2] ^ fl[3];
      default: ev = 1'b0;
    endcase
  endfunction

  task automatic dec(input op_form_type f, input logic [3:0] fld, input logic [7:0] cc,
      input logic [10:0] sa, input logic [3:0] fl);
    @(posedge clk_sys);
    dec_valid <= 1'b1;
    op_form <= f;
    operand_field <= fld;
    cond_code <= cc;
    short_bit_addr <= sa;
    flags <= fl;
    @(posedge clk_sys);
    dec_valid <= 1'b0;
    #1;
  endtask

  // Expected mode 00 skips the operand class and register checks
  task automatic chk(input logic [7:0] m, input logic [1:0] rs, input logic [2:0] b,
      input logic [3:0] c, input logic ct, input logic il);
    n_tests++;
    if (!(res_valid === 1'b1 && (m === 8'h00 || (addr_mode === m && reg_select === rs))
        && byte_count === b && cycle_count === c && cond_true === ct && illegal === il)) begin
      errors++;
      $display("MISMATCH %0t form %0d got %h %0d/%0d ct %b il %b", $time, op_form,
        addr_mode, byte_count, cycle_count, cond_true, illegal);
    end
  endtask

  task automatic idle_chk(input string what);
    n_tests++;
    if (!(res_valid === 1'b0 && addr_mode === AM_DATA_REG && byte_count === 3'h0
        && cycle_count === 4'h0 && cond_true === 1'b0 && illegal === 1'b0)) begin
      errors++;
      $display("MISMATCH %0t %s outputs not cleared", $time, what);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    idle_chk("reset");
    $display("Test reset done");
    @(posedge clk_sys);
    reset <= 1'b0;
    for (int f = 0; f < 16; f++) begin
      rows.push_back('{OP_CARRY_COMBINE, 4'(f), 3'(LN[cls(4'(f))]), 4'(CY0[cls(4'(f))])});
      rows.push_back('{OP_CLEAR_INVERT, 4'(f), 3'(LN[cls(4'(f))]), 4'(CY1[cls(4'(f))])});
      rows.push_back('{OP_MOVE_TO_OPND, 4'(f), 3'(LN[cls(4'(f))] + 1), 4'(CY3[cls(4'(f))])});
    end
    foreach (rows[i]) begin
      dec(rows[i].f, rows[i].fld, 8'hf9, 11'h000, 4'h0);
      t = (rows[i].f == OP_MOVE_TO_OPND);
      chk(mode_of(rows[i].fld), rows[i].fld[1:0], rows[i].b, rows[i].c, t, 1'b0);
    end
    $display("Test operand table done");
    for (int k = 0; k < 16; k++) begin
      for (int fl = 0; fl < 16; fl++) begin
        t = (k == 11 || k == 15) ? 1'b0 : ev(4'(k), 4'(fl));
        dec(OP_MOVE_TO_CARRY, 4'h2, {4'ha, 4'(k)}, 11'h000, 4'(fl));
        chk(8'h00, 2'h0, 3'h2, 4'h1 + 4'(t), t, (k == 11 || k == 15));
      end
    end
    $display("Test carry move conditions done");
    for (int i = 0; i < 17; i++) begin
      for (int fl = 0; fl < 16; fl++) begin
        t = (i < 14) ? ev(CK[i], 4'(fl)) : 1'b0;
        dec(OP_MOVE_TO_OPND, 4'h7, CB[i], 11'h000, 4'(fl));
        chk(8'h04, 2'h3, 3'h3, 4'ha, t, (i >= 14));
      end
    end
    $display("Test operand move conditions done");
    dec(OP_SHORT_CLR_INV, 4'h0, 8'h00, 11'h7ff, 4'hf);
    chk(8'h40, 2'h0, 3'h2, 4'h3, 1'b0, 1'b0);
    n_tests++;
    if (short_addr !== 11'h7ff) begin
      errors++;
      $display("MISMATCH %0t short address %h", $time, short_addr);
    end
    dec(op_form_type'(4'h9), 4'h0, 8'h00, 11'h401, 4'h0);
    n_tests++;
    if (res_valid !== 1'b1 || illegal !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t undefined form not flagged", $time);
    end
    @(posedge clk_sys);
    #1;
    n_tests++;
    if (res_valid !== 1'b0 || illegal !== 1'b1 || short_addr !== 11'h401) begin
      errors++;
      $display("MISMATCH %0t result not held", $time);
    end
    $display("Test short form and hold done");
    @(posedge clk_sys);
    dec_valid <= 1'b1;
    op_form <= OP_MOVE_TO_CARRY;
    cond_code <= 8'h00;
    flags <= 4'h1;
    @(posedge clk_sys);
    flags <= 4'h0;
    #1;
    chk(8'h00, 2'h0, 3'h2, 4'h2, 1'b1, 1'b0);
    @(posedge clk_sys);
    dec_valid <= 1'b0;
    #1;
    chk(8'h00, 2'h0, 3'h2, 4'h1, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    n_tests++;
    if (res_valid !== 1'b0) begin
      errors++;
      $display("MISMATCH %0t valid did not drop", $time);
    end
    $display("Test back to back done");
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    #1;
    idle_chk("mid reset");
    @(posedge clk_sys);
    reset <= 1'b0;
    dec(OP_CLEAR_INVERT, 4'hb, 8'h00, 11'h000, 4'h0);
    chk(8'h10, 2'h3, 3'h3, 4'h3, 1'b0, 1'b0);
    $display("Test reset recovery done");
    report_and_stop();
  end
endmodule // bit_instruction_decode_bench
